// [rtl/phy_link_mode_pkg.sv]
// constants, types and register map for the phy link mode control block
package phy_link_mode_pkg;

	localparam logic [7:0] ADDR_BASIC_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BASIC_STAT = 8'h01;
	localparam logic [7:0] ADDR_ADVERTISE = 8'h04;
	localparam logic [7:0] ADDR_PARTNER = 8'h05;
	localparam logic [7:0] ADDR_EXPANSION = 8'h06;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1A;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h1B;
	localparam logic [7:0] ADDR_PORT_CTRL = 8'h1C;
	localparam logic [7:0] ADDR_EEE_ADV = 8'h3C;
	localparam logic [3:0] ADDR_FILT_PAGE = 4'h4;

	localparam int CTRL_SPEED = 13;
	localparam int CTRL_AN_EN = 12;
	localparam int CTRL_RESTART = 9;
	localparam int CTRL_DUPLEX = 8;
	localparam int STAT_AN_DONE = 5;
	localparam int STAT_AN_ABLE = 3;
	localparam int STAT_LINK = 2;
	localparam int ADV_LO = 5;
	localparam int ADV_HI = 8;
	localparam int EXP_PARTNER_AN = 0;
	localparam int PCTL_AUTO_MDIX = 0;
	localparam int PCTL_FORCE_MDIX = 1;
	localparam int EEE_ADV_100 = 1;
	localparam int IRQ_LINK_UP = 0;
	localparam int IRQ_LINK_DOWN = 1;
	localparam int IRQ_AN_DONE = 2;

	localparam logic [15:0] CTRL_RESET = 16'h3100;
	localparam logic [15:0] ADV_RESET = 16'h05E1;
	localparam logic [15:0] PCTL_RESET = 16'h0001;
	localparam logic [15:0] EEE_ADV_RESET = 16'h0002;

	localparam logic [15:0] FILT_ON [16] = '{
		16'h0000, 16'h1F0F, 16'h1F1F, 16'h0010, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [15:0] FILT_OFF [16] = '{
		16'h0001, 16'h0E03, 16'h3020, 16'h2E36, 16'h0B1C, 16'h7E01,
		16'h7F7E, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};

	typedef enum logic [2:0] {
		ST_DOWN = 3'h1,
		ST_NEG = 3'h2,
		ST_UP = 3'h4
	} link_state_t;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
	} link_mode_t;

	typedef struct packed {
		logic page_valid;
		logic eee_np;
		logic [15:0] ability;
	} partner_page_t;

endpackage

// [rtl/phy_link_mode_control.sv]
// link establishment control for one integrated 10/100 phy port
`timescale 1ns/10ps
`default_nettype none

module phy_link_mode_control (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic emission_filter_strap,
	input wire logic fast_link_strap,
	input wire logic fast_link_speed_strap,
	input wire logic crossover_strap,
	input wire logic rx_signal_ok,
	input wire phy_link_mode_pkg::partner_page_t partner,
	input wire logic pd_detect_valid,
	input wire logic pd_speed_100,
	input wire logic mdix_sensed,
	output logic link_up,
	output phy_link_mode_pkg::link_mode_t mode,
	output logic an_active,
	output logic auto_mdix_on,
	output logic mdix_select,
	output logic eee_active,
	output logic filter_enable,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// state

	phy_link_mode_pkg::link_state_t state;
	phy_link_mode_pkg::link_state_t next_state;
	phy_link_mode_pkg::link_mode_t next_mode;
	logic straps_taken;
	logic fast_mode;
	logic xover_fixed;
	logic [15:0] ctrl;
	logic [15:0] adv;
	logic [15:0] partner_reg;
	logic partner_an_able;
	logic an_done;
	logic [15:0] port_ctrl;
	logic [15:0] eee_adv;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [2:0] next_stat;
	logic [15:0] filt [16];
	logic take_partner;
	logic an_done_hit;
	logic next_eee;

	////////////////////////////////////////////////////////////////////////
	// decode

	wire wr_ctrl = reg_wr && reg_addr == phy_link_mode_pkg::ADDR_BASIC_CTRL;
	wire wr_adv = reg_wr && reg_addr == phy_link_mode_pkg::ADDR_ADVERTISE;
	wire wr_pctl = reg_wr && reg_addr == phy_link_mode_pkg::ADDR_PORT_CTRL;
	wire wr_eee = reg_wr && reg_addr == phy_link_mode_pkg::ADDR_EEE_ADV;
	wire wr_mask = reg_wr && reg_addr == phy_link_mode_pkg::ADDR_IRQ_MASK;
	wire wr_stat = reg_wr && reg_addr == phy_link_mode_pkg::ADDR_IRQ_STAT;
	wire wr_filt = reg_wr && reg_addr[7:4] == phy_link_mode_pkg::ADDR_FILT_PAGE;
	wire capture = !straps_taken;

	// strap wins over bit 12 so software cannot undo fast link
	wire an_on = ctrl[phy_link_mode_pkg::CTRL_AN_EN] && !fast_mode;
	wire speed_change = wr_ctrl && state == phy_link_mode_pkg::ST_UP
		&& reg_wdata[phy_link_mode_pkg::CTRL_SPEED]
		!= ctrl[phy_link_mode_pkg::CTRL_SPEED];
	wire restart = wr_ctrl && an_on
		&& reg_wdata[phy_link_mode_pkg::CTRL_RESTART];
	wire an_toggle = wr_ctrl && reg_wdata[phy_link_mode_pkg::CTRL_AN_EN]
		!= ctrl[phy_link_mode_pkg::CTRL_AN_EN];
	wire drop_req = speed_change || restart || an_toggle;

	// common abilities, bit 3 = 100 full down to bit 0 = 10 half
	wire [3:0] common = adv[phy_link_mode_pkg::ADV_HI:phy_link_mode_pkg::ADV_LO]
		& partner.ability[phy_link_mode_pkg::ADV_HI:phy_link_mode_pkg::ADV_LO];
	wire phy_link_mode_pkg::link_mode_t forced = '{
		speed_100: ctrl[phy_link_mode_pkg::CTRL_SPEED],
		full_duplex: ctrl[phy_link_mode_pkg::CTRL_DUPLEX]};

	function automatic phy_link_mode_pkg::link_mode_t resolve(
		input logic [3:0] c);
		phy_link_mode_pkg::link_mode_t m;
		m = '{speed_100: 1'b0, full_duplex: 1'b0};
		if (c[3])
			m = '{speed_100: 1'b1, full_duplex: 1'b1};
		else if (c[2])
			m = '{speed_100: 1'b1, full_duplex: 1'b0};
		else if (c[1])
			m = '{speed_100: 1'b0, full_duplex: 1'b1};
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// link state machine

	always_comb
	begin
		next_state = state;
		next_mode = mode;
		next_eee = eee_active;
		take_partner = 1'b0;
		an_done_hit = 1'b0;
		case (state)
			phy_link_mode_pkg::ST_DOWN:
			begin
				if (straps_taken && rx_signal_ok && an_on)
					next_state = phy_link_mode_pkg::ST_NEG;
				else if (straps_taken && rx_signal_ok)
				begin
					// a negotiating partner falls back to detecting us
					next_state = phy_link_mode_pkg::ST_UP;
					next_mode = forced;
					next_eee = 1'b0;
				end
			end
			phy_link_mode_pkg::ST_NEG:
			begin
				if (!rx_signal_ok || !an_on)
					next_state = phy_link_mode_pkg::ST_DOWN;
				else if (partner.page_valid)
				begin
					take_partner = 1'b1;
					if (|common)
					begin
						next_state = phy_link_mode_pkg::ST_UP;
						next_mode = resolve(common);
						an_done_hit = 1'b1;
						next_eee = common[3] && partner.eee_np
							&& eee_adv[phy_link_mode_pkg::EEE_ADV_100];
					end
				end
				else if (pd_detect_valid)
				begin
					// parallel detection can only ever give half duplex
					next_state = phy_link_mode_pkg::ST_UP;
					next_mode = '{speed_100: pd_speed_100,
						full_duplex: 1'b0};
					next_eee = 1'b0;
				end
			end
			phy_link_mode_pkg::ST_UP:
			begin
				// mode is not touched here: new duplex waits for a relink
				if (!rx_signal_ok || drop_req)
					next_state = phy_link_mode_pkg::ST_DOWN;
			end
			default:
				next_state = phy_link_mode_pkg::ST_DOWN;
		endcase
	end

	wire ev_up = next_state == phy_link_mode_pkg::ST_UP && !link_up;
	wire ev_down = next_state != phy_link_mode_pkg::ST_UP && link_up;
	wire [2:0] events = {an_done_hit, ev_down, ev_up};
	wire [2:0] clr = wr_stat ? reg_wdata[2:0] : 3'h0;
	// a new event wins over a clear in the same cycle
	assign next_stat = (irq_stat & ~clr) | events;
	wire [2:0] next_mask = wr_mask ? reg_wdata[2:0] : irq_mask;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state <= phy_link_mode_pkg::ST_DOWN;
			mode <= '{speed_100: 1'b0, full_duplex: 1'b0};
			link_up <= 1'b0;
			eee_active <= 1'b0;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			irq <= 1'b0;
		end
		else
		begin
			state <= next_state;
			mode <= next_mode;
			link_up <= next_state == phy_link_mode_pkg::ST_UP;
			eee_active <= next_eee;
			irq_stat <= next_stat;
			irq_mask <= next_mask;
			irq <= |(next_stat & next_mask);
		end
	end

	wire next_auto = port_ctrl[phy_link_mode_pkg::PCTL_AUTO_MDIX] && !fast_mode;
	wire next_mdix = fast_mode ? xover_fixed
		: next_auto ? mdix_sensed
		: port_ctrl[phy_link_mode_pkg::PCTL_FORCE_MDIX];

	////////////////////////////////////////////////////////////////////////
	// straps and control registers

	// straps are caught on the first edge after reset release
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			straps_taken <= 1'b0;
			fast_mode <= 1'b0;
			xover_fixed <= 1'b0;
			filter_enable <= 1'b0;
		end
		else if (capture)
		begin
			straps_taken <= 1'b1;
			fast_mode <= fast_link_strap;
			xover_fixed <= crossover_strap;
			filter_enable <= emission_filter_strap;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			ctrl <= phy_link_mode_pkg::CTRL_RESET;
		else if (capture && fast_link_strap)
			ctrl[phy_link_mode_pkg::CTRL_SPEED] <= fast_link_speed_strap;
		else if (wr_ctrl)
			ctrl <= reg_wdata & ~(16'h0001 << phy_link_mode_pkg::CTRL_RESTART);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			adv <= phy_link_mode_pkg::ADV_RESET;
			port_ctrl <= phy_link_mode_pkg::PCTL_RESET;
			eee_adv <= phy_link_mode_pkg::EEE_ADV_RESET;
		end
		else
		begin
			if (wr_adv)
				adv <= reg_wdata;
			if (wr_pctl)
				port_ctrl <= reg_wdata;
			if (wr_eee)
				eee_adv <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			partner_reg <= 16'h0000;
			partner_an_able <= 1'b0;
			an_done <= 1'b0;
		end
		else
		begin
			if (take_partner)
			begin
				partner_reg <= partner.ability;
				partner_an_able <= 1'b1;
			end
			if (an_done_hit)
				an_done <= 1'b1;
			else if (next_state != phy_link_mode_pkg::ST_UP)
				an_done <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			an_active <= 1'b1;
			auto_mdix_on <= 1'b1;
			mdix_select <= 1'b0;
		end
		else
		begin
			an_active <= an_on;
			auto_mdix_on <= next_auto;
			mdix_select <= next_mdix;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// emission filter words, reloaded from the strap set at reset

	generate
		for (genvar i = 0; i < 16; i++)
		begin : g_filt
			always_ff @(posedge ref_clk)
			begin
				if (!rst_n)
					filt[i] <= 16'h0000;
				else if (capture)
					filt[i] <= emission_filter_strap
						? phy_link_mode_pkg::FILT_ON[i]
						: phy_link_mode_pkg::FILT_OFF[i];
				else if (wr_filt && reg_addr[3:0] == 4'(i))
					filt[i] <= reg_wdata;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// read path, data valid the cycle after the strobe

	wire [15:0] stat_word = (16'h0001 << phy_link_mode_pkg::STAT_AN_ABLE)
		| (16'(an_done) << phy_link_mode_pkg::STAT_AN_DONE)
		| (16'(link_up) << phy_link_mode_pkg::STAT_LINK);
	wire [15:0] rd_mux =
		reg_addr == phy_link_mode_pkg::ADDR_BASIC_CTRL ? ctrl
		: reg_addr == phy_link_mode_pkg::ADDR_BASIC_STAT ? stat_word
		: reg_addr == phy_link_mode_pkg::ADDR_ADVERTISE ? adv
		: reg_addr == phy_link_mode_pkg::ADDR_PARTNER ? partner_reg
		: reg_addr == phy_link_mode_pkg::ADDR_EXPANSION ? 16'(partner_an_able)
		: reg_addr == phy_link_mode_pkg::ADDR_IRQ_MASK ? {13'h0000, irq_mask}
		: reg_addr == phy_link_mode_pkg::ADDR_IRQ_STAT ? {13'h0000, irq_stat}
		: reg_addr == phy_link_mode_pkg::ADDR_PORT_CTRL ? port_ctrl
		: reg_addr == phy_link_mode_pkg::ADDR_EEE_ADV ? eee_adv
		: reg_addr[7:4] == phy_link_mode_pkg::ADDR_FILT_PAGE ? filt[reg_addr[3:0]]
		: 16'h0000;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_neg_pages;
		state == phy_link_mode_pkg::ST_NEG && rx_signal_ok && an_on
			&& partner.page_valid;
	endsequence

	sequence s_up_write;
		state == phy_link_mode_pkg::ST_UP && rx_signal_ok && wr_ctrl;
	endsequence

	a_prio_best: assert property (s_neg_pages ##0 common[3] |=> link_up
		&& mode.speed_100 && mode.full_duplex)
		else $error("best common mode not chosen");

	a_prio_ten_half: assert property (s_neg_pages ##0 common == 4'h1 |=>
		link_up && !mode.speed_100 && !mode.full_duplex)
		else $error("10 half not chosen");

	a_partner_store: assert property (s_neg_pages |=>
		partner_reg == $past(partner.ability)
		&& partner_an_able)
		else $error("partner ability not stored");

	a_pd_half: assert property (state == phy_link_mode_pkg::ST_NEG
		&& rx_signal_ok && an_on && !partner.page_valid && pd_detect_valid
		|=> link_up && !mode.full_duplex
		&& mode.speed_100 == $past(pd_speed_100))
		else $error("parallel detect mode wrong");

	a_forced_mode: assert property (state == phy_link_mode_pkg::ST_DOWN
		&& straps_taken && rx_signal_ok && !an_on
		|=> link_up && mode == $past(forced))
		else $error("forced mode not applied");

	a_speed_drop: assert property (s_up_write ##0 speed_change
		|=> !link_up && state == phy_link_mode_pkg::ST_DOWN)
		else $error("speed change kept link");

	a_duplex_hold: assert property (s_up_write ##0 !drop_req
		|=> link_up && $stable(mode))
		else $error("duplex applied without relink");

	a_fast_fixed: assert property (straps_taken && fast_mode |=>
		!an_active && !auto_mdix_on && mdix_select == xover_fixed)
		else $error("fast link left auto features on");

	a_irq_level: assert property (##1 irq == |(irq_stat & irq_mask))
		else $error("interrupt level mismatch");

	a_filter_load: assert property (capture ##1 1'b1 |-> filt[1]
		== (filter_enable ? 16'h1F0F : 16'h0E03))
		else $error("filter word not loaded");

endmodule

`default_nettype wire

// [testbench/link_partner_model.sv]
// behavioural model of the remote twisted-pair link partner
`timescale 1ns/10ps
`default_nettype none

module link_partner_model (
	input wire logic ref_clk,
	input wire logic [1:0] cmd,
	input wire logic [15:0] ability,
	input wire logic eee,
	input wire logic [3:0] dly,
	output logic rx_signal_ok,
	output phy_link_mode_pkg::partner_page_t partner,
	output logic pd_detect_valid,
	output logic pd_speed_100,
	output logic mdix_sensed
);
	// cmd: 0 silent, 1 negotiating, 2 fixed signalling only
	logic [3:0] cnt;

	// dly makes a slow partner: pages only after that many cycles
	always @(posedge ref_clk)
	begin
		rx_signal_ok <= (cmd != 2'h0);
		mdix_sensed <= (cmd != 2'h0);
		cnt <= (cmd == 2'h1 && cnt != dly) ? cnt + 4'h1 : cnt;
		if (cmd != 2'h1)
			cnt <= 4'h0;
		partner.page_valid <= (cmd == 2'h1) && (cnt == dly);
		partner.eee_np <= eee && (cmd == 2'h1);
		// a released page must not look valid, so it toggles
		partner.ability <= (cmd == 2'h1) ? ability : ~ability;
		pd_detect_valid <= (cmd == 2'h2);
		pd_speed_100 <= (cmd == 2'h2) ? ability[7] : ~ability[7];
	end
endmodule
`default_nettype wire

// [testbench/tb_phy_link_mode_control.sv]
// self-checking bench for the phy link mode control block
`timescale 1ns/10ps
`default_nettype none

module tb_phy_link_mode_control;
	logic ref_clk, rst_n, reg_wr, reg_rd, eee, rx_ok, pd_ok, pd_100, mdix;
	logic emission_filter_strap, fast_link_strap;
	logic fast_link_speed_strap, crossover_strap;
	logic link_up, an_active, auto_mdix_on, mdix_select, eee_active;
	logic filter_enable, irq;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, ab;
	logic [1:0] cmd;
	logic [3:0] dly;
	phy_link_mode_pkg::partner_page_t partner;
	phy_link_mode_pkg::link_mode_t mode;
	int n_fail, comparisons, cycles;
	localparam logic [15:0] ab_tbl [4] = '{16'h01E0, 16'h00E0,
		16'h0060, 16'h0020};
	localparam logic [1:0] md_tbl [4] = '{2'b11, 2'b10, 2'b01, 2'b00};

	phy_link_mode_control i_dut (
		.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .emission_filter_strap, .fast_link_strap,
		.fast_link_speed_strap, .crossover_strap, .rx_signal_ok(rx_ok),
		.partner, .pd_detect_valid(pd_ok), .pd_speed_100(pd_100),
		.mdix_sensed(mdix), .link_up, .mode, .an_active, .auto_mdix_on,
		.mdix_select, .eee_active, .filter_enable, .irq
	);

	link_partner_model i_partner (
		.ref_clk, .cmd, .ability(ab), .eee, .dly, .rx_signal_ok(rx_ok),
		.partner, .pd_detect_valid(pd_ok), .pd_speed_100(pd_100),
		.mdix_sensed(mdix)
	);

	////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task finish_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// a hang would otherwise never reach the verdict
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			finish_test();
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		if (seen !== exp)
			n_fail++;
	endtask

	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task rdc(input logic [7:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	task go(input logic [1:0] c, input logic [15:0] a, input logic e);
		@(posedge ref_clk);
		cmd <= c;
		ab <= a;
		eee <= e;
	endtask

	task wait_link(input logic lvl);
		int i;
		i = 0;
		while (link_up !== lvl && i < 60)
		begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		check({15'h0, link_up}, {15'h0, lvl});
	endtask

	task do_reset(input logic [3:0] s);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		{emission_filter_strap, fast_link_strap, fast_link_speed_strap,
			crossover_strap} <= s;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} <= '0;
		{cmd, ab, eee, dly} <= '0;
		n_fail = 0;
		comparisons = 0;
		cycles = 0;
		do_reset(4'b1000);
		check({an_active, auto_mdix_on, filter_enable, link_up}, 4'hE);
		rdc(phy_link_mode_pkg::ADDR_BASIC_CTRL, 16'h3100);
		rdc(phy_link_mode_pkg::ADDR_PORT_CTRL, 16'h0001);
		for (int k = 0; k < 16; k++)
			rdc({4'h4, 4'(k)}, phy_link_mode_pkg::FILT_ON[k]);
		rdc(8'h80, 16'h0000);
		wr(phy_link_mode_pkg::ADDR_BASIC_STAT, 16'hFFFF);
		rdc(phy_link_mode_pkg::ADDR_BASIC_STAT, 16'h0008);
		wr(phy_link_mode_pkg::ADDR_IRQ_MASK, 16'h0001);
		// one partner ability per pass, slower partner each time
		for (int k = 0; k < 4; k++)
		begin
			dly <= 4'(k);
			go(2'h1, ab_tbl[k], k == 0);
			wait_link(1'b1);
			check({15'h0, eee_active}, {15'h0, k == 0});
			rdc(phy_link_mode_pkg::ADDR_PARTNER, ab_tbl[k]);
			rdc(phy_link_mode_pkg::ADDR_EXPANSION, 16'h0001);
			rdc(phy_link_mode_pkg::ADDR_BASIC_STAT, 16'h002C);
			check({14'h0, mode}, {14'h0, md_tbl[k]});
			check({15'h0, irq}, 16'h0001);
			wr(phy_link_mode_pkg::ADDR_IRQ_STAT, 16'h0007);
			check({15'h0, irq}, 16'h0000);
			go(2'h0, 16'h0000, 1'b0);
			wait_link(1'b0);
		end
		dly <= 4'h0;
		go(2'h1, 16'h01E0, 1'b0);
		wait_link(1'b1);
		wr(phy_link_mode_pkg::ADDR_ADVERTISE, 16'h00E1);
		// a duplex bit write alone must not touch the live mode
		wr(phy_link_mode_pkg::ADDR_BASIC_CTRL, 16'h3000);
		repeat (4) @(posedge ref_clk);
		#1;
		check({14'h0, mode}, 16'h0003);
		check({15'h0, link_up}, 16'h0001);
		wr(phy_link_mode_pkg::ADDR_BASIC_CTRL, 16'h3300);
		wait_link(1'b0);
		wait_link(1'b1);
		check({14'h0, mode}, 16'h0002);
		rdc(phy_link_mode_pkg::ADDR_BASIC_CTRL, 16'h3100);
		go(2'h0, 16'h0000, 1'b0);
		wait_link(1'b0);
		go(2'h2, 16'h0080, 1'b0);
		wait_link(1'b1);
		check({14'h0, mode}, 16'h0002);
		wr(phy_link_mode_pkg::ADDR_BASIC_CTRL, 16'h2000);
		wait_link(1'b0);
		wait_link(1'b1);
		check({13'h0, an_active, mode}, 16'h0002);
		wr(phy_link_mode_pkg::ADDR_BASIC_CTRL, 16'h0100);
		wait_link(1'b0);
		wait_link(1'b1);
		check({14'h0, mode}, 16'h0001);
		// software weakens the filter through a word write
		wr({4'h4, 4'h1}, 16'h0E03);
		rdc({4'h4, 4'h1}, 16'h0E03);
		wr(phy_link_mode_pkg::ADDR_PORT_CTRL, 16'h0002);
		repeat (2) @(posedge ref_clk);
		#1;
		check({14'h0, auto_mdix_on, mdix_select}, 16'h0001);
		go(2'h0, 16'h0000, 1'b0);
		// second reset: fast link-up, 100 by strap, crossed pairs
		do_reset(4'b0111);
		check({an_active, auto_mdix_on, mdix_select, filter_enable}, 4'h2);
		rdc({4'h4, 4'h1}, 16'h0E03);
		go(2'h1, 16'h01E0, 1'b0);
		wait_link(1'b1);
		check({15'h0, mode.speed_100}, 16'h0001);
		wr(phy_link_mode_pkg::ADDR_BASIC_CTRL, 16'h0100);
		wait_link(1'b0);
		wait_link(1'b1);
		check({15'h0, mode.speed_100}, 16'h0000);
		finish_test();
	end
endmodule
`default_nettype wire
